// ---- verilog/dmau_map.svh ----
// Constants and field layout for the data memory access unit
// Overview of operation
// - Lower internal RAM sits at 00h-7Fh, reached directly or indirectly.
// - Lowest 32 bytes are four banks of eight registers chosen by bank bits.
// - Sixteen bytes above the banks hold 128 bits, bit addresses 00h-7Fh.
// - Upper internal RAM at 80h-FFh is reached only indirectly.
// - Direct accesses to 80h-FFh go to the special register segment.
// - Expanded on-chip RAM covers 0000h-07FFh via external-move instructions only.
// - Off-chip select bit 0 picks expanded RAM, 1 picks off-chip RAM.
// - Two-bit size field gives 256, 512, 1K or 2K bytes; above goes external.
// - Port 2 carries upper address; port 0 carries low address then data.
// - Latch strobe marks a valid low address byte on port 0.
// - Active-low read and write strobes drive external data memory.
// - Page access on: pointer moves put port 2 latch, not pointer high byte.
// - Indirect register moves put port 2 latch on port 2.
// - Page access: pointer values 0800h and up go off-chip regardless of size.
// - An external memory cycle lasts 6 CPU clocks.
// - Stretch bit widens strobes from 3 to 15 CPU clocks.
// - Two 16-bit data pointers; the select bit picks which one is seen.
// - Incrementing the pointer register toggles the select bit.
// - RAM contents are not initialised at reset.
// - Bit above the select bit always reads zero.
// - Aux control register resets to X000 1101.
// - Quiet bit clear: latch strobe pulses at CPU clock over three; set: moves only.
`ifndef DMAU_MAP_SVH
`define DMAU_MAP_SVH
`define DMAU_LOWER_TOP 8'h7f
`define DMAU_BIT_BASE 8'h20
`define DMAU_EXPANDED_ONCHIP_RAM_TOP 16'h07ff
`define DMAU_PAGE_LIMIT 16'h0800
`define DMAU_AUX_RESET 8'h0d
`define DMAU_AUX_QUIET 0
`define DMAU_AUX_OFFCHIP 1
`define DMAU_AUX_SIZE_LO 2
`define DMAU_AUX_PAGE 4
`define DMAU_AUX_STRETCH 5
`define DMAU_PTR_SEL 0
`define DMAU_PTR_ZERO 2
`define DMAU_PTR_FLAG 3
`define DMAU_CYC_NORMAL 4'h6
`define DMAU_STB_NORMAL 4'h3
`define DMAU_STB_STRETCH 4'hf
`define DMAU_ALE_DIV 2'h3
`endif

// ---- verilog/dmau_pkg.sv ----
// Types for the data memory access unit
package dmau_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STRB = 2'b10,
    ST_TAIL = 2'b11
  } dmau_state_type;
  typedef enum logic [1:0] {
    TGT_LOWER = 2'b00,
    TGT_UPPER = 2'b01,
    TGT_SFR = 2'b10,
    TGT_BIT = 2'b11
  } dmau_target_type;
endpackage

// ---- verilog/dmau_top.sv ----
// Data memory access unit: internal decode, external bus, dual pointers
`include "dmau_map.svh"
module dmau_top
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Internal space access
  input wire logic [7:0] i_int_addr,
  input wire logic i_int_indirect,
  input wire logic i_int_bitop,
  input wire logic i_int_wr,
  input wire logic i_int_req,
  input wire logic [7:0] i_int_wdata,
  input wire logic [1:0] i_bank_select,
  input wire logic [2:0] i_reg_num,
  input wire logic i_reg_access,
  output logic [7:0] o_int_rdata,
  output dmau_pkg::dmau_target_type o_int_target,
  output logic o_int_sfr_sel,
  output logic o_int_bit_rdata,
  // Control registers
  input wire logic i_aux_wr,
  input wire logic [7:0] i_aux_wdata,
  output logic [7:0] o_aux_control_reg,
  input wire logic i_ptr_reg_wr,
  input wire logic i_ptr_reg_inc,
  input wire logic [7:0] i_ptr_reg_wdata,
  output logic [7:0] o_aux_pointer_reg,
  // Data pointer access
  input wire logic i_ptr_lo_wr,
  input wire logic i_ptr_hi_wr,
  input wire logic [7:0] i_ptr_wdata,
  input wire logic i_ptr_inc,
  output logic [15:0] o_data_pointer,
  // External move request
  input wire logic i_xmv_req,
  input wire logic i_xmv_use_ptr,
  input wire logic i_xmv_wr,
  input wire logic [7:0] i_xmv_ri,
  input wire logic [7:0] i_xmv_wdata,
  input wire logic [7:0] i_port2_latch,
  output logic o_xmv_busy,
  output logic o_xmv_done,
  output logic [7:0] o_xmv_rdata,
  // External bus pins
  output logic [7:0] o_upper_address,
  output logic [7:0] o_muxed_addr_data,
  output logic o_muxed_addr_data_oe,
  input wire logic [7:0] i_muxed_addr_data,
  output logic o_addr_latch,
  output logic o_rd_n,
  output logic o_wr_n
);
  import dmau_pkg::*;

  // ---------------------------------------------------------------
  // Storage and helpers
  // ---------------------------------------------------------------
  // No reset on arrays: contents undefined at power-up
  logic [7:0] lower_ram [0:127];
  logic [7:0] upper_ram [0:127];
  logic [7:0] expanded_onchip_ram [0:2047];

  function automatic logic [15:0] expanded_onchip_ram_limit(input logic [1:0] size);
    expanded_onchip_ram_limit = 16'((16'h0100 << size) - 16'h0001);
  endfunction

  logic [7:0] aux_reg, aux_next;
  logic [7:0] ptrsel_reg, ptrsel_next;
  logic [15:0] data_pointer_zero_reg, data_pointer_zero_next, data_pointer_one_reg, data_pointer_one_next;
  logic [15:0] dp_reg, dp_next, ptr_upd;
  logic [7:0] int_rdata_reg, int_rdata_next;
  dmau_target_type tgt_reg, tgt_next;
  logic sfr_reg, sfr_next, bit_reg, bit_next;
  logic [7:0] din_s1_reg, din_s2_reg, din_s3_reg;

  // ---------------------------------------------------------------
  // Internal address decode
  // ---------------------------------------------------------------
  logic [7:0] eff_addr;
  logic [7:0] bit_byte;
  always_comb
  begin
    eff_addr = i_reg_access ? {3'b000, i_bank_select, i_reg_num} : i_int_addr;
    bit_byte = 8'(`DMAU_BIT_BASE + {4'h0, i_int_addr[6:3]});
    tgt_next = tgt_reg;
    sfr_next = 1'b0;
    bit_next = bit_reg;
    int_rdata_next = int_rdata_reg;
    if (i_int_req)
    begin
      if (i_int_bitop && !i_int_addr[7])
      begin
        tgt_next = TGT_BIT;
        bit_next = lower_ram[bit_byte[6:0]][i_int_addr[2:0]];
      end
      else if (eff_addr <= `DMAU_LOWER_TOP)
      begin
        tgt_next = TGT_LOWER;
        int_rdata_next = lower_ram[eff_addr[6:0]];
      end
      else if (i_int_indirect)
      begin
        tgt_next = TGT_UPPER;
        int_rdata_next = upper_ram[eff_addr[6:0]];
      end
      else
      begin
        tgt_next = TGT_SFR;
        sfr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_int_req && i_int_wr)
    begin
      if (i_int_bitop && !i_int_addr[7])
        lower_ram[bit_byte[6:0]][i_int_addr[2:0]] <= i_int_wdata[0];
      else if (eff_addr <= `DMAU_LOWER_TOP)
        lower_ram[eff_addr[6:0]] <= i_int_wdata;
      else if (i_int_indirect)
        upper_ram[eff_addr[6:0]] <= i_int_wdata;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      tgt_reg <= TGT_LOWER;
      sfr_reg <= 1'b0;
      bit_reg <= 1'b0;
      int_rdata_reg <= 8'h00;
    end
    else
    begin
      tgt_reg <= tgt_next;
      sfr_reg <= sfr_next;
      bit_reg <= bit_next;
      int_rdata_reg <= int_rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Control registers and dual pointers
  // ---------------------------------------------------------------
  logic [15:0] cur_ptr;
  always_comb
  begin
    cur_ptr = ptrsel_reg[`DMAU_PTR_SEL] ? data_pointer_one_reg : data_pointer_zero_reg;
    ptr_upd = cur_ptr;
    aux_next = aux_reg;
    if (i_aux_wr)
      aux_next = {1'b0, i_aux_wdata[6:0]};
    ptrsel_next = ptrsel_reg;
    if (i_ptr_reg_wr)
      ptrsel_next = i_ptr_reg_wdata;
    else if (i_ptr_reg_inc)
      ptrsel_next = 8'(ptrsel_reg + 8'h01);
    ptrsel_next[`DMAU_PTR_ZERO] = 1'b0;
    ptrsel_next[1] = 1'b0;
    data_pointer_zero_next = data_pointer_zero_reg;
    data_pointer_one_next = data_pointer_one_reg;
    if (i_ptr_lo_wr)
      ptr_upd[7:0] = i_ptr_wdata;
    if (i_ptr_hi_wr)
      ptr_upd[15:8] = i_ptr_wdata;
    if (i_ptr_inc)
      ptr_upd = 16'(cur_ptr + 16'h0001);
    if (i_ptr_lo_wr || i_ptr_hi_wr || i_ptr_inc)
    begin
      if (ptrsel_reg[`DMAU_PTR_SEL])
        data_pointer_one_next = ptr_upd;
      else
        data_pointer_zero_next = ptr_upd;
    end
    // Visible pointer registered so the output needs no mux
    dp_next = ptrsel_next[`DMAU_PTR_SEL] ? data_pointer_one_next : data_pointer_zero_next;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      aux_reg <= `DMAU_AUX_RESET;
      ptrsel_reg <= 8'h00;
      data_pointer_zero_reg <= 16'h0000;
      data_pointer_one_reg <= 16'h0000;
      dp_reg <= 16'h0000;
    end
    else
    begin
      aux_reg <= aux_next;
      ptrsel_reg <= ptrsel_next;
      data_pointer_zero_reg <= data_pointer_zero_next;
      data_pointer_one_reg <= data_pointer_one_next;
      dp_reg <= dp_next;
    end
  end

  // ---------------------------------------------------------------
  // External move sequencer
  // ---------------------------------------------------------------
  dmau_state_type st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] ale_div_reg, ale_div_next;
  logic wr_cyc_reg, wr_cyc_next, done_reg, done_next, busy_reg, busy_next;
  logic [7:0] p2_reg, p2_next, p0_reg, p0_next, wd_reg, wd_next, rd_reg, rd_next;
  logic p0_oe_reg, p0_oe_next, ale_reg, ale_next, rdn_reg, rdn_next, wrn_reg, wrn_next;
  logic [15:0] xaddr;
  logic onchip;
  logic [3:0] strobe_len;

  always_comb
  begin
    xaddr = i_xmv_use_ptr ? cur_ptr : {8'h00, i_xmv_ri};
    // Page mode forces pointer moves at or above the page limit off-chip
    onchip = !aux_reg[`DMAU_AUX_OFFCHIP]
      && (xaddr <= expanded_onchip_ram_limit(aux_reg[`DMAU_AUX_SIZE_LO +: 2]))
      && !(i_xmv_use_ptr && aux_reg[`DMAU_AUX_PAGE] && xaddr >= `DMAU_PAGE_LIMIT);
    strobe_len = aux_reg[`DMAU_AUX_STRETCH] ? `DMAU_STB_STRETCH : `DMAU_STB_NORMAL;
    st_next = st_reg;
    cnt_next = cnt_reg;
    ale_div_next = (ale_div_reg == `DMAU_ALE_DIV - 2'h1) ? 2'h0 : 2'(ale_div_reg + 2'h1);
    wr_cyc_next = wr_cyc_reg;
    done_next = 1'b0;
    p2_next = p2_reg;
    p0_next = p0_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    p0_oe_next = p0_oe_reg;
    rdn_next = 1'b1;
    wrn_next = 1'b1;
    // Free-running strobe unless quieted
    ale_next = !aux_reg[`DMAU_AUX_QUIET] && (ale_div_reg == 2'h0);
    unique case (st_reg)
      ST_IDLE:
      begin
        p2_next = i_port2_latch;
        p0_oe_next = 1'b0;
        if (i_xmv_req && onchip)
        begin
          done_next = 1'b1;
          rd_next = expanded_onchip_ram[xaddr[10:0]];
        end
        else if (i_xmv_req)
        begin
          // Port 2 keeps its latch for indirect or page moves
          p2_next = (i_xmv_use_ptr && !aux_reg[`DMAU_AUX_PAGE]) ? xaddr[15:8] : i_port2_latch;
          p0_next = xaddr[7:0];
          p0_oe_next = 1'b1;
          ale_next = 1'b1;
          wr_cyc_next = i_xmv_wr;
          wd_next = i_xmv_wdata;
          cnt_next = 4'h1;
          st_next = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        ale_next = 1'b0;
        p0_next = wd_reg;
        p0_oe_next = wr_cyc_reg;
        rdn_next = wr_cyc_reg;
        wrn_next = !wr_cyc_reg;
        cnt_next = 4'h1;
        st_next = ST_STRB;
      end
      ST_STRB:
      begin
        ale_next = 1'b0;
        rdn_next = wr_cyc_reg;
        wrn_next = !wr_cyc_reg;
        cnt_next = 4'(cnt_reg + 4'h1);
        if (cnt_reg == strobe_len)
        begin
          rdn_next = 1'b1;
          wrn_next = 1'b1;
          st_next = ST_TAIL;
        end
      end
      ST_TAIL:
      begin
        // Cycle totals six clocks unstretched
        ale_next = 1'b0;
        p0_oe_next = 1'b0;
        done_next = 1'b1;
        // Three-flop delay: this sample was taken inside the strobe
        if (!wr_cyc_reg)
          rd_next = din_s3_reg;
        st_next = ST_IDLE;
      end
    endcase
    busy_next = (st_next != ST_IDLE);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_xmv_req && onchip && i_xmv_wr && st_reg == ST_IDLE)
      expanded_onchip_ram[xaddr[10:0]] <= i_xmv_wdata;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      st_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      ale_div_reg <= 2'h0;
      wr_cyc_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      p2_reg <= 8'hff;
      p0_reg <= 8'h00;
      wd_reg <= 8'h00;
      rd_reg <= 8'h00;
      p0_oe_reg <= 1'b0;
      ale_reg <= 1'b0;
      rdn_reg <= 1'b1;
      wrn_reg <= 1'b1;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
      din_s3_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      ale_div_reg <= ale_div_next;
      wr_cyc_reg <= wr_cyc_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      p2_reg <= p2_next;
      p0_reg <= p0_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      p0_oe_reg <= p0_oe_next;
      ale_reg <= ale_next;
      rdn_reg <= rdn_next;
      wrn_reg <= wrn_next;
      din_s1_reg <= i_muxed_addr_data;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
    end
  end

  assign o_int_rdata = int_rdata_reg;
  assign o_int_target = tgt_reg;
  assign o_int_sfr_sel = sfr_reg;
  assign o_int_bit_rdata = bit_reg;
  assign o_aux_control_reg = aux_reg;
  assign o_aux_pointer_reg = ptrsel_reg;
  assign o_data_pointer = dp_reg;
  assign o_xmv_busy = busy_reg;
  assign o_xmv_done = done_reg;
  assign o_xmv_rdata = rd_reg;
  assign o_upper_address = p2_reg;
  assign o_muxed_addr_data = p0_reg;
  assign o_muxed_addr_data_oe = p0_oe_reg;
  assign o_addr_latch = ale_reg;
  assign o_rd_n = rdn_reg;
  assign o_wr_n = wrn_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_PTR_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !ptrsel_reg[`DMAU_PTR_ZERO]) else $error("pointer zero bit set");
  AST_TOGGLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_ptr_reg_inc && !i_ptr_reg_wr) |=> ptrsel_reg[0] != $past(ptrsel_reg[0]))
    else $error("increment did not toggle select");
  AST_STB_LEN: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!aux_reg[`DMAU_AUX_STRETCH] && $fell(o_rd_n)) |-> !o_rd_n[*3] ##1 o_rd_n)
    else $error("read strobe width wrong");
  AST_CYCLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (st_reg == ST_IDLE && st_next == ST_ADDR && !aux_reg[`DMAU_AUX_STRETCH] && !i_aux_wr)
    |-> ##6 done_reg) else $error("external cycle not six clocks");
  AST_ALE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (st_reg == ST_ADDR) |-> (o_addr_latch && o_muxed_addr_data_oe))
    else $error("address strobe missing");
  AST_PAGE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (st_reg == ST_IDLE && st_next == ST_ADDR && aux_reg[`DMAU_AUX_PAGE])
    |=> o_upper_address == $past(i_port2_latch)) else $error("page mode drove pointer");
  AST_SFR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (i_int_req && !i_int_indirect && !i_int_bitop && !i_reg_access && i_int_addr[7])
    |=> o_int_sfr_sel) else $error("direct upper not routed to sfr");
  AST_QUIET: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (aux_reg[`DMAU_AUX_QUIET] && $past(aux_reg[`DMAU_AUX_QUIET]) && st_reg == ST_IDLE
    && $past(st_reg) == ST_IDLE) |-> !o_addr_latch)
    else $error("strobe while quiet");
  AST_RDWR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !(!o_rd_n && !o_wr_n)) else $error("both strobes low");
endmodule

// ---- dv/dmau_xmem.sv ----
// Behavioural external data memory with its address latch
module dmau_xmem
(
  // Bus pins seen from the memory side
  input wire logic i_addr_latch,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_upper_address,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [15:0] addr_reg;
  // Latch takes the address once on the strobe's rise and holds it until the next rise;
  // the address settles just after the clock edge, so it is taken 1 ns later
  always @(posedge i_addr_latch) #1 addr_reg = {i_upper_address, i_bus};
  // Released bus flips so stale data can never pass as a read
  initial
  begin
    o_bus = 8'h00;
    forever
    begin
      @(i_rd_n);
      if (i_rd_n === 1'b0)
        o_bus = mem[addr_reg];
      else
        o_bus = ~o_bus;
    end
  end
  always @(posedge i_wr_n) mem[addr_reg] = i_bus;
endmodule

// ---- dv/dmau_top_test.sv ----
// Self-checking bench for the data memory access unit
module dmau_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dmau_pkg::*;
  logic i_sys_clk, i_reset, i_int_indirect, i_int_bitop, i_int_wr, i_int_req, i_reg_access;
  logic [7:0] i_int_addr, i_int_wdata, i_aux_wdata, i_ptr_reg_wdata, i_ptr_wdata;
  logic [7:0] i_xmv_ri, i_xmv_wdata, i_port2_latch, o_int_rdata, o_aux_control_reg;
  logic [7:0] o_aux_pointer_reg, o_xmv_rdata, o_upper_address, o_muxed_addr_data, mem_bus;
  logic [1:0] i_bank_select;
  logic [2:0] i_reg_num;
  logic i_aux_wr, i_ptr_reg_wr, i_ptr_reg_inc, i_ptr_lo_wr, i_ptr_hi_wr, i_ptr_inc;
  logic i_xmv_req, i_xmv_use_ptr, i_xmv_wr, o_int_sfr_sel, o_int_bit_rdata, o_xmv_busy;
  logic o_xmv_done, o_muxed_addr_data_oe, o_addr_latch, o_rd_n, o_wr_n;
  logic [15:0] o_data_pointer;
  dmau_target_type o_int_target;
  wire logic [7:0] i_muxed_addr_data;
  int miscompares, comparisons, done_at, strobe_low, ale_cnt;
  logic [7:0] p0_at_ale, p2_at_ale;
  // Only one party may own the shared lines at a time
  assign i_muxed_addr_data = o_muxed_addr_data_oe ? o_muxed_addr_data : mem_bus;
  dmau_top uut (.*);
  dmau_xmem xmem (.i_addr_latch(o_addr_latch), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_upper_address(o_upper_address), .i_bus(i_muxed_addr_data), .o_bus(mem_bus));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_sys_clk);
    s = 1'b1;
    @(negedge i_sys_clk);
    s = 1'b0;
  endtask
  task automatic int_acc(input logic [7:0] a, input logic ind, bop, wr, input logic [7:0] d);
    i_int_addr = a;
    i_int_indirect = ind;
    i_int_bitop = bop;
    i_int_wr = wr;
    i_int_wdata = d;
    pulse(i_int_req);
  endtask
  task automatic set_aux(input logic [7:0] v);
    i_aux_wdata = v;
    pulse(i_aux_wr);
  endtask
  task automatic set_ptr(input logic [15:0] v);
    i_ptr_wdata = v[7:0];
    pulse(i_ptr_lo_wr);
    i_ptr_wdata = v[15:8];
    pulse(i_ptr_hi_wr);
  endtask
  task automatic count_ale(input int n);
    ale_cnt = 0;
    repeat (n)
    begin
      @(negedge i_sys_clk);
      if (o_addr_latch === 1'b1) ale_cnt++;
    end
  endtask
  task automatic xmv(input logic ptr, wr, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_xmv_use_ptr = ptr;
    i_xmv_wr = wr;
    i_xmv_wdata = d;
    i_xmv_req = 1'b1;
    done_at = 0;
    strobe_low = 0;
    for (int n = 1; n < 40 && done_at == 0; n++)
    begin
      @(negedge i_sys_clk);
      i_xmv_req = 1'b0;
      if (o_addr_latch === 1'b1)
      begin
        p0_at_ale = o_muxed_addr_data;
        p2_at_ale = o_upper_address;
      end
      if (o_rd_n === 1'b0 || o_wr_n === 1'b0) strobe_low++;
      if (o_xmv_done === 1'b1) done_at = n;
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    check(o_aux_control_reg, 8'h0d);
    check(o_aux_pointer_reg[2:0], 3'h0);
    check({o_rd_n, o_wr_n, o_muxed_addr_data_oe}, 3'h6);
    count_ale(9);
    check(ale_cnt, 0);
  endtask
  task automatic t_internal();
    i_reg_access = 1'b1;
    for (int b = 0; b < 4; b++)
    begin
      i_bank_select = b[1:0];
      int_acc(8'h00, 1'b0, 1'b0, 1'b1, 8'h40 + b[7:0]);
    end
    i_reg_access = 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      int_acc(8'h05 + 8'(b * 8), 1'b0, 1'b0, 1'b0, 8'h00);
      check(o_int_rdata, 8'h40 + b[7:0]);
    end
    int_acc(8'h15, 1'b1, 1'b0, 1'b0, 8'h00);
    check(o_int_rdata, 8'h42);
    int_acc(8'h21, 1'b0, 1'b0, 1'b1, 8'h00);
    int_acc(8'h0a, 1'b0, 1'b1, 1'b1, 8'h01);
    int_acc(8'h21, 1'b0, 1'b0, 1'b0, 8'h00);
    check(o_int_rdata, 8'h04);
    int_acc(8'h0a, 1'b0, 1'b1, 1'b0, 8'h00);
    check({o_int_target, o_int_bit_rdata}, {TGT_BIT, 1'b1});
    int_acc(8'h90, 1'b1, 1'b0, 1'b1, 8'h3c);
    int_acc(8'h90, 1'b1, 1'b0, 1'b0, 8'h00);
    check({o_int_target, o_int_rdata}, {TGT_UPPER, 8'h3c});
    int_acc(8'h90, 1'b0, 1'b0, 1'b0, 8'h00);
    check({o_int_target, o_int_sfr_sel}, {TGT_SFR, 1'b1});
  endtask
  task automatic t_ptr();
    set_ptr(16'h1111);
    pulse(i_ptr_inc);
    check(o_data_pointer, 16'h1112);
    pulse(i_ptr_reg_inc);
    set_ptr(16'h2222);
    check(o_data_pointer, 16'h2222);
    pulse(i_ptr_reg_inc);
    check(o_data_pointer, 16'h1112);
    i_ptr_reg_wdata = 8'hff;
    pulse(i_ptr_reg_wr);
    check(o_aux_pointer_reg, 8'hf9);
    pulse(i_ptr_reg_inc);
    check(o_aux_pointer_reg, 8'hf8);
  endtask
  task automatic t_ext();
    set_aux(8'h03);
    set_ptr(16'h1234);
    xmv(1'b1, 1'b1, 8'h5a);
    check({done_at[7:0], strobe_low[7:0]}, 16'h0603);
    check({p2_at_ale, p0_at_ale}, 16'h1234);
    xmv(1'b1, 1'b0, 8'h00);
    check({o_xmv_rdata, strobe_low[7:0]}, 16'h5a03);
    set_aux(8'h23);
    xmv(1'b1, 1'b0, 8'h00);
    check({done_at[7:0], strobe_low[7:0], o_xmv_rdata}, 24'h120f5a);
    i_port2_latch = 8'ha5;
    i_xmv_ri = 8'h40;
    set_aux(8'h03);
    xmv(1'b0, 1'b1, 8'h66);
    check({p2_at_ale, p0_at_ale}, 16'ha540);
    set_aux(8'h0f);
    set_ptr(16'h0012);
    xmv(1'b1, 1'b1, 8'h77);
    check(done_at, 6);
    for (int s = 0; s < 4; s++)
    begin
      set_aux({4'h0, s[1:0], 2'b01});
      set_ptr(16'(16'h0100 << s) - 16'h0001);
      xmv(1'b1, 1'b1, 8'h11);
      check({done_at[7:0], strobe_low[7:0]}, 16'h0100);
      set_ptr(16'(16'h0100 << s));
      xmv(1'b1, 1'b1, 8'h11);
      check(done_at, 6);
    end
    set_aux(8'h1d);
    set_ptr(16'h0900);
    xmv(1'b1, 1'b1, 8'h22);
    check({done_at[7:0], p2_at_ale}, 16'h06a5);
    set_ptr(16'h07ff);
    xmv(1'b1, 1'b1, 8'h22);
    check(done_at, 1);
    xmv(1'b1, 1'b0, 8'h00);
    check({done_at[7:0], o_xmv_rdata}, 16'h0122);
  endtask
  task automatic t_ale();
    set_aux(8'h0c);
    count_ale(30);
    check(ale_cnt, 10);
    set_aux(8'h0d);
  endtask
  // --------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    {i_int_indirect, i_int_bitop, i_int_wr, i_int_req, i_reg_access, i_aux_wr} = '0;
    {i_ptr_reg_wr, i_ptr_reg_inc, i_ptr_lo_wr, i_ptr_hi_wr, i_ptr_inc, i_xmv_req} = '0;
    {i_xmv_use_ptr, i_xmv_wr, i_bank_select, i_reg_num} = '0;
    {i_int_addr, i_int_wdata, i_aux_wdata, i_ptr_reg_wdata, i_ptr_wdata} = '0;
    {i_xmv_ri, i_xmv_wdata, i_port2_latch} = '0;
    i_reset = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    i_reset = 1'b0;
    t_reset();
    i_reg_num = 3'h5;
    t_internal();
    t_ptr();
    t_ext();
    t_ale();
    finish_test();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #50us;
    miscompares++;
    finish_test();
  end
endmodule
